//--- pm4_consts.vh
// constants for the four-channel 8+4 dithered modulator: register map, field positions, reset values, timing
// assumes inclusion by bare name from every design file of the block
`ifndef PM4_CONSTS_VH
`define PM4_CONSTS_VH

// geometry
`define PM4_NCH          4
`define PM4_ADDR_W       4
`define PM4_DATA_W       8
`define PM4_CNT_W        12
`define PM4_POS_W        8
`define PM4_SUB_W        4
`define PM4_CNT_LAST     12'hfff
`define PM4_CNT_ZERO     12'h000

// register byte offsets
`define PM4_A_DUTY_LOW0  4'h0
`define PM4_A_DUTY_HIGH0 4'h1
`define PM4_A_PORT_OUT   4'h8
`define PM4_A_PORT_DIR   4'h9
`define PM4_A_PULL_UP    4'ha
`define PM4_A_PORT_IN    4'hb
`define PM4_A_STATUS     4'hc
`define PM4_A_PAIR_SEL   3
`define PM4_A_PAIR_TOP   4'h7
`define PM4_PAIR_STRIDE  2

// low register fields
`define PM4_FINE_HI      7
`define PM4_FINE_LO      4
`define PM4_EN_BIT       0

// reset values
`define PM4_RST_BYTE     8'h00
`define PM4_RST_FINE     4'h0
`define PM4_RST_PORT     4'h0
`define PM4_RST_DIR      4'hf
`define PM4_RST_CNT      12'h000
`define PM4_READ_ZERO    8'h00

`endif

//--- pm4_cnt.v
// shared free-running cycle counter for all modulator channels
// assumes a single system clock and a synchronous active-low reset
`include "pm4_consts.vh"
`default_nettype none

module pm4_cnt (
  input  wire                    clk,
  input  wire                    resetn,
  output reg  [`PM4_CNT_W-1:0]   cnt_r,
  output wire                    cycle_start
);

  // counts every system clock, wraps after 4096
  always @(posedge clk) begin
    if (!resetn) begin
      cnt_r <= `PM4_RST_CNT;
    end else if (cnt_r == `PM4_CNT_LAST) begin
      cnt_r <= `PM4_CNT_ZERO;
    end else begin
      cnt_r <= cnt_r + 12'h001;
    end
  end

  // first clock of each full cycle
  assign cycle_start = (cnt_r == `PM4_CNT_ZERO);

endmodule // pm4_cnt

`default_nettype wire

//--- pm4_chan.v
// one 8+4 modulator channel with a duty shadow reloaded at full-cycle start
// assumes the shared counter and its cycle_start flag from the top level
`include "pm4_consts.vh"
`default_nettype none

module pm4_chan (
  input  wire                    clk,
  input  wire                    resetn,
  input  wire                    cycle_start,
  input  wire [`PM4_SUB_W-1:0]   sub_idx,
  input  wire [`PM4_POS_W-1:0]   pos,
  input  wire [`PM4_POS_W-1:0]   coarse_count,
  input  wire [`PM4_SUB_W-1:0]   fine_dither_count,
  output reg                     mod_out_ch
);

  reg  [`PM4_POS_W-1:0] coarse_r;
  reg  [`PM4_SUB_W-1:0] fine_r;
  wire [`PM4_POS_W-1:0] coarse_use;
  wire [`PM4_SUB_W-1:0] fine_use;
  wire                  extra;
  wire [`PM4_POS_W:0]   thr;

  // shadow copy so a full cycle never mixes old and new duty
  always @(posedge clk) begin
    if (!resetn) begin
      coarse_r <= `PM4_RST_BYTE;
      fine_r   <= `PM4_RST_FINE;
    end else if (cycle_start) begin
      coarse_r <= coarse_count;
      fine_r   <= fine_dither_count;
    end
  end

  // at cycle start the incoming value is already the one in force
  assign coarse_use = cycle_start ? coarse_count : coarse_r;
  assign fine_use   = cycle_start ? fine_dither_count : fine_r;

  // one extra high clock in the first fine sub-cycles spreads the low bits
  assign extra = (sub_idx < fine_use);
  assign thr   = {1'b0, coarse_use} + {{`PM4_POS_W{1'b0}}, extra};

  // registered output lags the counter by one clock, same for every channel
  always @(posedge clk) begin
    if (!resetn) begin
      mod_out_ch <= 1'b0;
    end else begin
      mod_out_ch <= ({1'b0, pos} < thr);
    end
  end

endmodule // pm4_chan

`default_nettype wire

//--- pm4_top.v
// top of the four-channel modulator: register port, counter, channels, pin muxing
// assumes a synchronous bus master and pin inputs synchronous to clk
`include "pm4_consts.vh"
`default_nettype none

module pm4_top (
  input  wire                    clk,
  input  wire                    resetn,
  input  wire [`PM4_ADDR_W-1:0]  addr,
  input  wire [`PM4_DATA_W-1:0]  wdata,
  input  wire                    wr_en,
  input  wire                    rd_en,
  output reg  [`PM4_DATA_W-1:0]  rdata_r,
  input  wire [`PM4_NCH-1:0]     shared_port_pin_in,
  output wire [`PM4_NCH-1:0]     shared_port_pin_out,
  output wire [`PM4_NCH-1:0]     shared_port_pin_oe_n,
  output wire [`PM4_NCH-1:0]     pull_up_en
);

  wire [`PM4_CNT_W-1:0] cnt;
  wire                  cycle_start;
  wire [`PM4_NCH-1:0]   mod_out_ch;

  reg  [`PM4_NCH-1:0]   port_out_reg_r;
  reg  [`PM4_NCH-1:0]   port_dir_r;
  reg  [`PM4_NCH-1:0]   pull_up_r;
  reg  [`PM4_DATA_W-1:0] rd_nxt;

  // per-channel duty fields, flattened for the read mux
  wire [`PM4_NCH*`PM4_POS_W-1:0] coarse_flat;
  wire [`PM4_NCH*`PM4_SUB_W-1:0] fine_flat;
  wire [`PM4_NCH-1:0]            en_flat;

  // shared counter: sixteen sub-cycles of 256 clocks inside 4096
  pm4_cnt u_cnt (
    .clk         (clk),
    .resetn      (resetn),
    .cnt_r       (cnt),
    .cycle_start (cycle_start)
  );

  // port configuration registers
  always @(posedge clk) begin
    if (!resetn) begin
      port_out_reg_r <= `PM4_RST_PORT;
      port_dir_r     <= `PM4_RST_DIR;
      pull_up_r      <= `PM4_RST_PORT;
    end else if (wr_en) begin
      if (addr == `PM4_A_PORT_OUT) begin
        port_out_reg_r <= wdata[`PM4_NCH-1:0];
      end
      if (addr == `PM4_A_PORT_DIR) begin
        port_dir_r <= wdata[`PM4_NCH-1:0];
      end
      if (addr == `PM4_A_PULL_UP) begin
        pull_up_r <= wdata[`PM4_NCH-1:0];
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < `PM4_NCH; g = g + 1) begin : g_ch
      reg  [`PM4_POS_W-1:0] duty_high_reg_r;
      reg  [`PM4_SUB_W-1:0] duty_low_fine_r;
      reg                   duty_low_en_r;
      wire [`PM4_ADDR_W-1:0] a_low;
      wire [`PM4_ADDR_W-1:0] a_high;

      // pair addresses are worked out at full integer width, then cut to the bus width on purpose
      localparam [31:0] A_LOW_W  = `PM4_A_DUTY_LOW0  + `PM4_PAIR_STRIDE * g;
      localparam [31:0] A_HIGH_W = `PM4_A_DUTY_HIGH0 + `PM4_PAIR_STRIDE * g;

      assign a_low  = A_LOW_W[`PM4_ADDR_W-1:0];
      assign a_high = A_HIGH_W[`PM4_ADDR_W-1:0];

      // duty pair: high holds coarse, low holds fine and enable
      always @(posedge clk) begin
        if (!resetn) begin
          duty_high_reg_r <= `PM4_RST_BYTE;
          duty_low_fine_r <= `PM4_RST_FINE;
          duty_low_en_r   <= 1'b0;
        end else if (wr_en) begin
          if (addr == a_high) begin
            duty_high_reg_r <= wdata;
          end
          if (addr == a_low) begin
            duty_low_fine_r <= wdata[`PM4_FINE_HI:`PM4_FINE_LO];
            duty_low_en_r   <= wdata[`PM4_EN_BIT];
          end
        end
      end

      assign coarse_flat[g*`PM4_POS_W +: `PM4_POS_W] = duty_high_reg_r;
      assign fine_flat[g*`PM4_SUB_W +: `PM4_SUB_W]   = duty_low_fine_r;
      assign en_flat[g]                              = duty_low_en_r;

      // independent modulator per channel
      pm4_chan u_chan (
        .clk               (clk),
        .resetn            (resetn),
        .cycle_start       (cycle_start),
        .sub_idx           (cnt[`PM4_CNT_W-1:`PM4_POS_W]),
        .pos               (cnt[`PM4_POS_W-1:0]),
        .coarse_count      (duty_high_reg_r),
        .fine_dither_count (duty_low_fine_r),
        .mod_out_ch        (mod_out_ch[g])
      );

      // pin mux: direction input releases the pin, else data bit gates the waveform when enabled, or drives the pin alone
      assign shared_port_pin_oe_n[g] = port_dir_r[g];
      assign shared_port_pin_out[g]  = duty_low_en_r ? (port_out_reg_r[g] & mod_out_ch[g])
                                                     : port_out_reg_r[g];
      assign pull_up_en[g]           = port_dir_r[g] & pull_up_r[g];
    end
  endgenerate

  // read mux; unmapped addresses and unused bits read zero
  always @* begin
    rd_nxt = `PM4_READ_ZERO;
    if (addr <= `PM4_A_PAIR_TOP) begin
      if (addr[0]) begin
        rd_nxt = coarse_flat[addr[`PM4_A_PAIR_SEL-1:1]*`PM4_POS_W +: `PM4_POS_W];
      end else begin
        rd_nxt[`PM4_FINE_HI:`PM4_FINE_LO] = fine_flat[addr[`PM4_A_PAIR_SEL-1:1]*`PM4_SUB_W +: `PM4_SUB_W];
        rd_nxt[`PM4_EN_BIT]               = en_flat[addr[`PM4_A_PAIR_SEL-1:1]];
      end
    end else begin
      case (addr)
        `PM4_A_PORT_OUT: rd_nxt[`PM4_NCH-1:0] = port_out_reg_r;
        `PM4_A_PORT_DIR: rd_nxt[`PM4_NCH-1:0] = port_dir_r;
        `PM4_A_PULL_UP:  rd_nxt[`PM4_NCH-1:0] = pull_up_r;
        `PM4_A_PORT_IN:  rd_nxt[`PM4_NCH-1:0] = shared_port_pin_in;
        `PM4_A_STATUS:   rd_nxt[`PM4_SUB_W-1:0] = cnt[`PM4_CNT_W-1:`PM4_POS_W];
        default:         rd_nxt = `PM4_READ_ZERO;
      endcase
    end
  end

  // read data stand in the cycle after the strobe only
  always @(posedge clk) begin
    if (!resetn) begin
      rdata_r <= `PM4_READ_ZERO;
    end else if (rd_en) begin
      rdata_r <= rd_nxt;
    end else begin
      rdata_r <= `PM4_READ_ZERO;
    end
  end

endmodule // pm4_top

`default_nettype wire

//--- pm4_chk_assertions.sv
// checker for the modulator top: pin control, read port and sub-cycle timing
// assumes only the top ports; it shadows port, direction and enable writes
`include "pm4_consts.vh"
`default_nettype none
module pm4_chk (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr_en,
  input wire logic       rd_en,
  input wire logic [7:0] rdata_r,
  input wire logic [3:0] shared_port_pin_out,
  input wire logic [3:0] shared_port_pin_oe_n,
  input wire logic [3:0] pull_up_en
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] port_r;
  logic [3:0] dir_r;
  logic [3:0] en_r;
  logic [7:0] ph_r;
  // mirrors the low byte of the block's free-running counter; both leave reset at the same edge
  always_ff @(posedge clk) begin
    if (!resetn) ph_r <= 8'h00;
    else ph_r <= ph_r + 8'h01;
  end
  // shadow copies reset like the block, so checks hold from the first edge
  always_ff @(posedge clk) begin
    if (!resetn) begin
      port_r <= 4'h0;
      dir_r  <= 4'hf;
      en_r   <= 4'h0;
    end else if (wr_en) begin
      if (addr == 4'h8) port_r <= wdata[3:0];
      if (addr == 4'h9) dir_r <= wdata[3:0];
      if (!addr[3] && !addr[0]) en_r[addr[2:1]] <= wdata[0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_stat; rd_en && addr == 4'hc; endsequence
  sequence s_low; rd_en && !addr[3] && !addr[0]; endsequence
  // ch0 live means its pin is an enabled output with port bit set
  // a port bit write would also raise the pin, so the port bit must have held still
  sequence s_rise0;
    $rose(shared_port_pin_out[0]) && en_r[0] && !dir_r[0] && port_r[0] && $stable(port_r[0]);
  endsequence
  a_oe_dir: assert property (shared_port_pin_oe_n == dir_r)
    else $error("output enable differs from direction");
  a_pull_input: assert property ((pull_up_en & ~shared_port_pin_oe_n) == 4'h0)
    else $error("pull-high on a driven pin");
  a_port_low: assert property ((~dir_r & ~port_r & shared_port_pin_out) == 4'h0)
    else $error("pin high with port bit clear");
  a_plain_port: assert property ((~dir_r & ~en_r & (shared_port_pin_out ^ port_r)) == 4'h0)
    else $error("disabled pin not following port bit");
  // the registered output lags the counter, so a waveform rise shows one clock into a sub-cycle;
  // a sub-cycle with zero high clocks may follow, so only the place of each rise is checked
  a_sub_period: assert property (s_rise0 |-> ph_r == 8'h01)
    else $error("pin rise off the sub-cycle boundary");
  a_low_unused: assert property (s_low |=> rdata_r[3:1] == 3'b000)
    else $error("low register unused bits set");
  a_stat_range: assert property (s_stat |=> rdata_r[7:4] == 4'h0)
    else $error("sub-cycle index above 15");
  a_read_idle: assert property (!rd_en |=> rdata_r == 8'h00)
    else $error("read data outside its cycle");
endmodule // pm4_chk
bind pm4_top pm4_chk u_pm4_chk (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr_en(wr_en),
  .rd_en(rd_en), .rdata_r(rdata_r), .shared_port_pin_out(shared_port_pin_out),
  .shared_port_pin_oe_n(shared_port_pin_oe_n), .pull_up_en(pull_up_en));
`default_nettype wire

//--- pm4_load.sv
// pin load model: resolves each shared pin from block drive, pull-high and outside level
// assumes an active-low output enable from the block
`default_nettype none
module pm4_load (
  input  wire logic [3:0] drv,
  input  wire logic [3:0] oe_n,
  input  wire logic [3:0] pull,
  input  wire logic [3:0] ext,
  output var  logic [3:0] lvl
);
  timeunit 1ns;
  timeprecision 100ps;
  // released pins float high through the pull, else take the outside level
  assign lvl = (~oe_n & drv) | (oe_n & pull) | (oe_n & ~pull & ext);
endmodule // pm4_load
`default_nettype wire

//--- test_pwm_8plus4_four_channel.sv
// self-checking bench for the four-channel dithered modulator
// assumes pm4_top, the pin load model and the bound checker
`default_nettype none
module test_pwm_8plus4_four_channel;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk = 1'b0;
  logic       resetn = 1'b0;
  logic       wr_en = 1'b0;
  logic       rd_en = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [3:0] ext = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rv;
  logic [11:0] t;
  logic [7:0] l;
  wire  [7:0] rdata_r;
  wire  [3:0] pin, oe_n, pull, lvl;
  int         error_cnt = 0;
  int         checks = 0;
  // rows: duty value, then the longest high run it must give
  logic [19:0] rows [5] = '{20'h0_0000, 20'h0_0101, 20'h6_4064, 20'h8_0f81, 20'h7_f380};
  initial forever #10 clk = ~clk;
  pm4_top u_pm4_top (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata_r(rdata_r), .shared_port_pin_in(lvl), .shared_port_pin_out(pin), .shared_port_pin_oe_n(oe_n),
    .pull_up_en(pull));
  pm4_load u_pm4_load (.drv(pin), .oe_n(oe_n), .pull(pull), .ext(ext), .lvl(lvl));
  task automatic results;
    if (error_cnt == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string n, input logic [11:0] e, input logic [11:0] s);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 rv = rdata_r;
  endtask
  // one full cycle of the pin: high clocks and longest high run
  task automatic meas(input int c);
    logic [7:0] run;
    t = 0;
    l = 0;
    run = 0;
    repeat (4096) begin
      @(posedge clk);
      #1 run = lvl[c] ? run + 8'h01 : 8'h00;
      t = t + 12'(lvl[c]);
      if (run > l) l = run;
    end
  endtask
  initial begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    wr(4'h9, 8'h00);
    wr(4'h8, 8'h0f);
    foreach (rows[i]) begin
      wr(4'(2 * (i % 4) + 1), rows[i][19:12]);
      wr(4'(2 * (i % 4)), {rows[i][11:8], 4'h1});
      // new value waits for the next full cycle, so skip one before measuring
      repeat (4100) @(posedge clk);
      meas(i % 4);
      chk("total high", rows[i][19:8], t);
      chk("longest run", {4'h0, rows[i][7:0]}, {4'h0, l});
    end
    wr(4'h8, 8'h0e);
    meas(0);
    chk("gated pin", 12'h000, t);
    wr(4'h9, 8'h01);
    wr(4'ha, 8'h01);
    rd(4'hb);
    chk("input oe_n", 12'h001, 12'(oe_n[0]));
    chk("pull-high", 12'h001, 12'(rv[0]));
    wr(4'h0, 8'hff);
    rd(4'h0);
    chk("low reg", 12'h0f1, 12'(rv));
    rd(4'hf);
    chk("unmapped", 12'h000, 12'(rv));
    rd(4'hc);
    chk("status top", 12'h000, 12'(rv[7:4]));
    @(posedge clk);
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk("reset oe_n", 12'h00f, 12'(oe_n));
    chk("reset pins", 12'h000, {pin, pull, rdata_r[3:0]});
    results;
  end
  // watchdog sized for about five rows of two full cycles each
  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    results;
  end
endmodule // test_pwm_8plus4_four_channel
`default_nettype wire
